// >>> amp_scaler_pkg.sv
package amp_scaler_pkg;

  // ==========================================================================
  // Register map, byte addresses
  localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
  localparam logic [7:0]  BASE_AMPL_OFFSET  = 8'h04;
  localparam logic [7:0]  GRAD_OFFSET       = 8'h08;
  localparam logic [7:0]  THRESH_OFFSET     = 8'h0c;
  localparam logic [7:0]  INTERVAL_OFFSET   = 8'h10;
  localparam logic [7:0]  STATUS_OFFSET     = 8'h14;

  // ==========================================================================
  // Field positions
  localparam int          CTRL_AUTO_BIT     = 0;
  localparam int          CTRL_MRES_LSB     = 4;
  localparam int          STATUS_VOLT_BIT   = 8;

  // ==========================================================================
  // Widths and reset values
  localparam int          STEP_W            = 20;
  localparam int          AMPL_W            = 8;
  localparam int          DIVIDEND_W        = 24;
  localparam int          NORM_SHIFT        = 16;
  localparam logic [3:0]  MRES_MAX          = 4'h8;
  localparam logic [7:0]  BASE_AMPL_RESET   = 8'h80;
  localparam logic [7:0]  GRAD_RESET        = 8'h04;
  localparam logic [19:0] THRESH_RESET      = 20'h00000;
  localparam logic [19:0] INTERVAL_MAX      = 20'hfffff;
  localparam logic [7:0]  AMPL_MAX          = 8'hff;

  // ==========================================================================
  // Bus answers
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  typedef struct packed {
    logic [3:0] mres;
    logic       autoscale;
  } ctrl_t;

  typedef struct packed {
    logic [7:0]  base_amplitude;
    logic [7:0]  amplitude_velocity_gain;
    logic [19:0] chopper_transition_threshold;
  } settings_t;

  typedef enum logic {
    CHOP_VOLTAGE,
    CHOP_CURRENT
  } chop_state_t;

endpackage

// >>> step_divider.sv
`timescale 1ns/100ps
`default_nettype none

module step_divider #(
  parameter int NUM_W = 24,
  parameter int DEN_W = 20
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Request
  input  wire logic             start_i,
  input  wire logic [NUM_W-1:0] dividend_i,
  input  wire logic [DEN_W-1:0] divisor_i,
  // Answer
  output logic                  done_o,
  output logic      [NUM_W-1:0] quotient_o
);

  localparam int CNT_W = $clog2(NUM_W + 1);

  logic             busy;
  logic [CNT_W-1:0] count;
  logic [NUM_W-1:0] num;
  logic [DEN_W:0]   rem;
  logic [DEN_W-1:0] den;
  logic             next_busy;
  logic [CNT_W-1:0] next_count;
  logic [NUM_W-1:0] next_num;
  logic [DEN_W:0]   next_rem;
  logic [DEN_W-1:0] next_den;
  logic             next_done;
  logic [NUM_W-1:0] next_quotient;
  logic [DEN_W:0]   trial;

  // ==========================================================================
  // Restoring division, one quotient bit per cycle
  always_comb
  begin
    next_busy     = busy;
    next_count    = count;
    next_num      = num;
    next_rem      = rem;
    next_den      = den;
    next_done     = 1'b0;
    next_quotient = quotient_o;
    trial         = {rem[DEN_W-1:0], num[NUM_W-1]};
    if (start_i)
    begin
      next_busy  = 1'b1;
      next_count = CNT_W'(NUM_W);
      next_num   = dividend_i;
      next_rem   = '0;
      next_den   = (divisor_i == '0) ? DEN_W'(1) : divisor_i;
    end
    else if (busy)
    begin
      if (trial >= {1'b0, den})
      begin
        next_rem = trial - {1'b0, den};
        next_num = {num[NUM_W-2:0], 1'b1};
      end
      else
      begin
        next_rem = trial;
        next_num = {num[NUM_W-2:0], 1'b0};
      end
      next_count = count - CNT_W'(1);
      if (count == CNT_W'(1))
      begin
        next_busy     = 1'b0;
        next_done     = 1'b1;
        next_quotient = next_num;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy       <= 1'b0;
      count      <= '0;
      num        <= '0;
      rem        <= '0;
      den        <= '0;
      done_o     <= 1'b0;
      quotient_o <= '0;
    end
    else
    begin
      busy       <= next_busy;
      count      <= next_count;
      num        <= next_num;
      rem        <= next_rem;
      den        <= next_den;
      done_o     <= next_done;
      quotient_o <= next_quotient;
    end
  end

endmodule

`default_nettype wire

// >>> voltage_pwm_amplitude_scaler.sv
`timescale 1ns/100ps
`default_nettype none

module voltage_pwm_amplitude_scaler
  import amp_scaler_pkg::*;
(
  // Clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        SYS_RST_I,
  // Motion and current feedback
  input  wire logic        STEP_I,
  input  wire logic        CHOP_PERIOD_I,
  input  wire logic        CUR_LOW_I,
  input  wire logic        CUR_HIGH_I,
  // Amplitude out
  output logic [7:0]       PWM_SCALE_O,
  output logic             VOLT_MODE_O,
  // AXI4-Lite write
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  // ==========================================================================
  // Register bus
  ctrl_t       ctrl, next_ctrl;
  settings_t   cfg, next_cfg;
  logic        aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [19:0] step_interval;

  always_comb
  begin
    next_ctrl    = ctrl;
    next_cfg     = cfg;
    next_aw_held = aw_held | (S_AXI_AWVALID & S_AXI_AWREADY);
    next_w_held  = w_held | (S_AXI_WVALID & S_AXI_WREADY);
    next_aw_addr = (S_AXI_AWVALID & S_AXI_AWREADY) ? S_AXI_AWADDR : aw_addr;
    next_w_data  = (S_AXI_WVALID & S_AXI_WREADY) ? S_AXI_WDATA : w_data;
    next_w_strb  = (S_AXI_WVALID & S_AXI_WREADY) ? S_AXI_WSTRB : w_strb;
    next_bvalid  = S_AXI_BVALID & ~S_AXI_BREADY;
    next_bresp   = S_AXI_BRESP;
    if (aw_held && w_held && !S_AXI_BVALID)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      unique case (aw_addr)
        CTRL_OFFSET:
        begin
          if (w_strb[0])
          begin
            next_ctrl.autoscale = w_data[CTRL_AUTO_BIT];
            next_ctrl.mres      = (w_data[CTRL_MRES_LSB+:4] > MRES_MAX) ? MRES_MAX : w_data[CTRL_MRES_LSB+:4];
          end
        end
        BASE_AMPL_OFFSET: if (w_strb[0]) next_cfg.base_amplitude = w_data[7:0];
        GRAD_OFFSET:      if (w_strb[0]) next_cfg.amplitude_velocity_gain = w_data[7:0];
        THRESH_OFFSET:
        begin
          if (w_strb[0]) next_cfg.chopper_transition_threshold[7:0]   = w_data[7:0];
          if (w_strb[1]) next_cfg.chopper_transition_threshold[15:8]  = w_data[15:8];
          if (w_strb[2]) next_cfg.chopper_transition_threshold[19:16] = w_data[19:16];
        end
        INTERVAL_OFFSET, STATUS_OFFSET: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready  = ~next_w_held & ~next_bvalid;
    next_rvalid  = S_AXI_RVALID & ~S_AXI_RREADY;
    next_rdata   = S_AXI_RDATA;
    next_rresp   = S_AXI_RRESP;
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      unique case (S_AXI_ARADDR)
        CTRL_OFFSET:      next_rdata = {24'h000000, ctrl.mres, 3'h0, ctrl.autoscale};
        BASE_AMPL_OFFSET: next_rdata = {24'h000000, cfg.base_amplitude};
        GRAD_OFFSET:      next_rdata = {24'h000000, cfg.amplitude_velocity_gain};
        THRESH_OFFSET:    next_rdata = {12'h000, cfg.chopper_transition_threshold};
        INTERVAL_OFFSET:  next_rdata = {12'h000, step_interval};
        STATUS_OFFSET:    next_rdata = {23'h000000, VOLT_MODE_O, PWM_SCALE_O};
        default:
        begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      ctrl          <= '0;
      cfg           <= {BASE_AMPL_RESET, GRAD_RESET, THRESH_RESET};
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= RESP_OKAY;
    end
    else
    begin
      ctrl          <= next_ctrl;
      cfg           <= next_cfg;
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      S_AXI_AWREADY <= next_awready;
      S_AXI_WREADY  <= next_wready;
      S_AXI_BVALID  <= next_bvalid;
      S_AXI_BRESP   <= next_bresp;
      S_AXI_ARREADY <= next_arready;
      S_AXI_RVALID  <= next_rvalid;
      S_AXI_RDATA   <= next_rdata;
      S_AXI_RRESP   <= next_rresp;
    end
  end

  // ==========================================================================
  // Step interval measurement and rate division
  logic [19:0] cycle_count, next_cycle_count, next_step_interval;
  logic        step_prev, step_edge, div_start, next_div_start, div_done;
  logic [23:0] quotient, dividend;

  assign step_edge = STEP_I & ~step_prev;
  // Gain times 2^16 over interval times 2^mres: rate at 256 steps, scaled by 256
  assign dividend  = {cfg.amplitude_velocity_gain, 16'h0000} >> ctrl.mres;

  always_comb
  begin
    next_cycle_count   = (cycle_count == INTERVAL_MAX) ? cycle_count : cycle_count + 20'h00001;
    next_step_interval = step_interval;
    next_div_start     = 1'b0;
    if (step_edge)
    begin
      next_step_interval = next_cycle_count;
      next_cycle_count   = 20'h00000;
      next_div_start     = 1'b1;
    end
    else if (cycle_count == INTERVAL_MAX)
      next_step_interval = INTERVAL_MAX;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      cycle_count   <= 20'h00000;
      step_interval <= INTERVAL_MAX;
      step_prev     <= 1'b0;
      div_start     <= 1'b0;
    end
    else
    begin
      cycle_count   <= next_cycle_count;
      step_interval <= next_step_interval;
      step_prev     <= STEP_I;
      div_start     <= next_div_start;
    end
  end

  step_divider #(
    .NUM_W      (DIVIDEND_W),
    .DEN_W      (STEP_W)
  ) u_divider (
    .clk_i      (SYS_CLK_I),
    .rst_i      (SYS_RST_I),
    .start_i    (div_start),
    .dividend_i (dividend),
    .divisor_i  (step_interval),
    .done_o     (div_done),
    .quotient_o (quotient)
  );

  // ==========================================================================
  // Chopper choice and amplitude
  chop_state_t state, next_state;
  logic        volt_sel;
  logic [8:0]  ff_sum, up_sum;
  logic [7:0]  ff_amp, next_scale;

  assign volt_sel = step_interval >= cfg.chopper_transition_threshold;
  assign ff_sum   = {1'b0, cfg.base_amplitude} + ((quotient > 24'h0000ff) ? 9'h0ff : {1'b0, quotient[7:0]});
  assign ff_amp   = ff_sum[8] ? AMPL_MAX : ff_sum[7:0];
  assign up_sum   = {1'b0, PWM_SCALE_O} + {1'b0, cfg.amplitude_velocity_gain};

  always_comb
  begin
    next_state = state;
    next_scale = PWM_SCALE_O;
    unique case (state)
      CHOP_VOLTAGE:
      begin
        if (!volt_sel)
          next_state = CHOP_CURRENT;
        else if (ctrl.autoscale)
        begin
          if (CHOP_PERIOD_I && CUR_LOW_I)
            next_scale = up_sum[8] ? AMPL_MAX : up_sum[7:0];
          else if (CHOP_PERIOD_I && CUR_HIGH_I)
            next_scale = (PWM_SCALE_O > cfg.amplitude_velocity_gain) ? PWM_SCALE_O - cfg.amplitude_velocity_gain : 8'h00;
        end
        else if (div_done)
          next_scale = ff_amp;
      end
      CHOP_CURRENT:
      begin
        if (volt_sel)
        begin
          next_state = CHOP_VOLTAGE;
          // With autoscale base amplitude caps the held value on restart, otherwise base amplitude sets it
          if (ctrl.autoscale && PWM_SCALE_O < cfg.base_amplitude)
            next_scale = PWM_SCALE_O;
          else
            next_scale = cfg.base_amplitude;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      state       <= CHOP_VOLTAGE;
      PWM_SCALE_O <= 8'h00;
      VOLT_MODE_O <= 1'b1;
    end
    else
    begin
      state       <= next_state;
      PWM_SCALE_O <= next_scale;
      VOLT_MODE_O <= (next_state == CHOP_VOLTAGE);
    end
  end

  // ==========================================================================
  // Checks
  sequence s_measure;
    step_edge ##1 div_start;
  endsequence

  property p_divide_done;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    s_measure ##1 (!step_edge)[*8] |-> ##[1:20] div_done;
  endproperty
  a_divide_done: assert property (p_divide_done) else $error("divider gave no answer");

  property p_ff_load;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    state == CHOP_VOLTAGE && volt_sel && !ctrl.autoscale && div_done |=> PWM_SCALE_O == $past(ff_amp);
  endproperty
  a_ff_load: assert property (p_ff_load) else $error("feed-forward amplitude not loaded");

  property p_ff_floor;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    div_done |-> ff_amp >= cfg.base_amplitude;
  endproperty
  a_ff_floor: assert property (p_ff_floor) else $error("amplitude below base");

  property p_to_current;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    state == CHOP_VOLTAGE && !volt_sel |=> !VOLT_MODE_O && state == CHOP_CURRENT;
  endproperty
  a_to_current: assert property (p_to_current) else $error("no switch to current chopper");

  property p_zero_thresh;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    cfg.chopper_transition_threshold == 20'h00000 ##1 cfg.chopper_transition_threshold == 20'h00000 |-> VOLT_MODE_O;
  endproperty
  a_zero_thresh: assert property (p_zero_thresh) else $error("left voltage chopper at zero threshold");

  property p_hold;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    state == CHOP_CURRENT && !volt_sel |=> $stable(PWM_SCALE_O);
  endproperty
  a_hold: assert property (p_hold) else $error("amplitude moved in current mode");

  property p_return;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    state == CHOP_CURRENT && volt_sel |=> VOLT_MODE_O && PWM_SCALE_O <= $past(cfg.base_amplitude);
  endproperty
  a_return: assert property (p_return) else $error("restart amplitude above base");

  property p_auto_up;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    state == CHOP_VOLTAGE && volt_sel && ctrl.autoscale && CHOP_PERIOD_I && CUR_LOW_I && !up_sum[8]
    |=> PWM_SCALE_O == $past(up_sum[7:0]);
  endproperty
  a_auto_up: assert property (p_auto_up) else $error("regulator did not raise amplitude");

  property p_resp_hold;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("write response dropped");

endmodule

`default_nettype wire

// >>> coil_step_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Step pulse source and coil current sense
module coil_step_model
  import amp_scaler_pkg::*;
#(
  parameter int CHOP_DIV = 64
) (
  // Clock
  input  wire logic        clk_i,
  // Bench control
  input  wire logic        run_i,
  input  wire logic [19:0] period_i,
  input  wire logic [7:0]  target_i,
  // Amplitude applied to coils
  input  wire logic [7:0]  scale_i,
  // Towards the block
  output logic             step_o,
  output logic             chop_o,
  output logic             low_o,
  output logic             high_o
);
  logic [19:0] step_cnt;
  logic [7:0]  chop_cnt;

  initial
  begin
    step_cnt = 20'h00000;
    chop_cnt = 8'h00;
    {step_o, chop_o, low_o, high_o} = 4'h0;
  end

  // Evenly spaced steps, motor stands still when stopped
  always @(posedge clk_i)
  begin
    if (!run_i || step_cnt >= period_i - 20'h00001)
      step_cnt <= 20'h00000;
    else
      step_cnt <= step_cnt + 20'h00001;
    step_o <= run_i && (step_cnt < (period_i >> 1));
  end

  // Coil current compared with target every clock, chopper strobe once per CHOP_DIV clocks
  always @(posedge clk_i)
  begin
    chop_cnt <= (chop_cnt == 8'(CHOP_DIV - 1)) ? 8'h00 : chop_cnt + 8'h01;
    chop_o   <= (chop_cnt == 8'h00);
    low_o    <= scale_i < target_i;
    high_o   <= scale_i > target_i;
  end
endmodule

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Bench for the amplitude scaler
module tb_top
  import amp_scaler_pkg::*;
;
  localparam int CHOP_DIV = 64;
  logic        clk, rst, run, step, chop, cur_low, cur_high, volt_mode;
  logic [19:0] period;
  logic [7:0]  target, pwm_scale, awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  wstrb;
  int          err_count, n_checks, k, b, g, p;
  logic [31:0] rst_tab [5];

  voltage_pwm_amplitude_scaler i_voltage_pwm_amplitude_scaler (
    .SYS_CLK_I(clk), .SYS_RST_I(rst), .STEP_I(step), .CHOP_PERIOD_I(chop),
    .CUR_LOW_I(cur_low), .CUR_HIGH_I(cur_high), .PWM_SCALE_O(pwm_scale), .VOLT_MODE_O(volt_mode),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  coil_step_model #(.CHOP_DIV(CHOP_DIV)) i_coil_step_model (
    .clk_i(clk), .run_i(run), .period_i(period), .target_i(target), .scale_i(pwm_scale),
    .step_o(step), .chop_o(chop), .low_o(cur_low), .high_o(cur_high));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================
  // Expectation and reporting
  function automatic logic [7:0] ff_scale(int base, int gain, int kk, int per);
    int v;
    v = (gain << (16 - kk)) / per;
    v = (v > 255) ? 255 : v;
    v = v + base;
    return (v > 255) ? 8'hff : v[7:0];
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================
  // AXI4-Lite master
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  initial
  begin
    #(90000 * 4);
    err_count++;
    test_done();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    {rst, run, period, target} = {1'b1, 1'b0, 20'd100, 8'h80};
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    err_count = 0;
    n_checks = 0;
    rst_tab = '{32'h0, 32'(BASE_AMPL_RESET), 32'(GRAD_RESET), 32'(THRESH_RESET), 32'(INTERVAL_MAX)};
    void'($urandom(58275));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(volt_mode), 32'h1, "voltage mode at reset");
    for (int i = 0; i < 5; i++)
    begin
      rdr(8'(4 * i), rd, rs);
      chk(rd, rst_tab[i], "reset value");
    end
    wr(8'h18, 32'h5a, rs);
    chk(32'(rs), 32'(RESP_SLVERR), "unmapped write");
    rdr(8'h18, rd, rs);
    chk({rd[29:0], rs}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(INTERVAL_OFFSET, 32'h0, rs);
    rdr(INTERVAL_OFFSET, rd, rs);
    chk(rd, 32'(INTERVAL_MAX), "read-only interval");
    // Single byte lane of the threshold
    wstrb <= 4'h2;
    wr(THRESH_OFFSET, 32'h000abcde, rs);
    wstrb <= 4'hf;
    rdr(THRESH_OFFSET, rd, rs);
    chk(rd, 32'h0000bc00, "byte lane write");
    wr(THRESH_OFFSET, 32'h0, rs);
    // Feed-forward amplitude, saturating and random cases
    for (int i = 0; i < 6; i++)
    begin
      k = (i == 0) ? 0 : $urandom_range(8);
      b = (i == 0) ? 200 : (i == 1) ? 255 : $urandom_range(255);
      g = (i == 0) ? 255 : $urandom_range(255);
      p = (i == 0) ? 40 : $urandom_range(1500, 40);
      wr(CTRL_OFFSET, 32'(k << CTRL_MRES_LSB), rs);
      wr(BASE_AMPL_OFFSET, 32'(b), rs);
      wr(GRAD_OFFSET, 32'(g), rs);
      period <= 20'(p);
      run <= 1'b1;
      repeat (3 * p + 60) @(posedge clk);
      rdr(INTERVAL_OFFSET, rd, rs);
      chk(rd, 32'(p), "step interval");
      chk(32'(pwm_scale), 32'(ff_scale(b, g, k, p)), "feed-forward amplitude");
      chk(32'(volt_mode), 32'h1, "zero threshold");
      rdr(STATUS_OFFSET, rd, rs);
      chk(rd, {23'h000000, 1'b1, ff_scale(b, g, k, p)}, "status word");
    end
    // Raising the threshold moves the drive into current mode
    wr(CTRL_OFFSET, 32'h80, rs);
    wr(BASE_AMPL_OFFSET, 32'h30, rs);
    wr(GRAD_OFFSET, 32'h40, rs);
    wr(THRESH_OFFSET, 32'd400, rs);
    period <= 20'd500;
    repeat (1600) @(posedge clk);
    chk(32'(volt_mode), 32'h1, "interval above threshold");
    wr(THRESH_OFFSET, 32'd1000, rs);
    wr(GRAD_OFFSET, 32'h90, rs);
    repeat (1100) @(posedge clk);
    chk(32'(volt_mode), 32'h0, "current mode");
    chk(32'(pwm_scale), 32'(ff_scale(8'h30, 8'h40, 8, 500)), "held amplitude");
    // Falling velocity brings the voltage chopper back, threshold untouched
    period <= 20'd1200;
    for (int t = 0; t < 2600 && volt_mode !== 1'b1; t++)
      @(posedge clk);
    chk(32'(volt_mode), 32'h1, "voltage mode at low velocity");
    chk(32'(pwm_scale), 32'h30, "reload of base");
    repeat (1100) @(posedge clk);
    chk(32'(pwm_scale), 32'(ff_scale(8'h30, 8'h90, 8, 1200)), "amplitude after return");
    // Automatic regulation from standstill
    run <= 1'b0;
    wr(THRESH_OFFSET, 32'h0, rs);
    wr(GRAD_OFFSET, 32'h4, rs);
    wr(CTRL_OFFSET, 32'h1, rs);
    foreach (rst_tab[i])
    begin
      if (i > 1)
        break;
      target <= (i == 0) ? 8'ha0 : 8'h30;
      repeat (200 * CHOP_DIV) @(posedge clk);
      chk(32'(pwm_scale + 8'h04 - target <= 8'h08), 32'h1, "regulated amplitude");
    end
    test_done();
  end
endmodule

`default_nettype wire
